// ---- hdl/ssp_pkg.sv ----
package ssp_pkg;

	// Register byte offsets on the APB slave.
	localparam logic [7:0] ADDR_RX_STATUS = 8'h00;
	localparam logic [7:0] ADDR_TX_BUF = 8'h04;
	localparam logic [7:0] ADDR_TX_STATUS = 8'h08;
	localparam logic [7:0] ADDR_BAUD_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_DIV_HIGH = 8'h10;
	localparam logic [7:0] ADDR_DIV_LOW = 8'h14;
	localparam logic [7:0] ADDR_RX_BUF = 8'h18;
	localparam logic [7:0] ADDR_IRQ_CTRL = 8'h1C;

	// Receive status and control field positions.
	localparam int RS_PORT_EN = 7;
	localparam int RS_RX9_EN = 6;
	localparam int RS_SINGLE_EN = 5;
	localparam int RS_CONT_EN = 4;
	localparam int RS_FRAME_ERR = 2;
	localparam int RS_OVERRUN = 1;
	localparam int RS_RX_NINTH = 0;

	// Transmit status and control field positions.
	localparam int TS_CLK_SRC = 7;
	localparam int TS_TX9_EN = 6;
	localparam int TS_TX_EN = 5;
	localparam int TS_SYNC = 4;
	localparam int TS_SHIFT_EMPTY = 1;
	localparam int TS_TX_NINTH = 0;

	// Interrupt control fields: enables low, flags above.
	localparam int IC_TX_IE = 0;
	localparam int IC_RX_IE = 1;
	localparam int IC_TX_FLAG = 4;
	localparam int IC_RX_FLAG = 5;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] TX_STATUS_RESET = 8'h02;
	localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
	localparam logic [3:0] BITS_SHORT = 4'h8;
	localparam logic [3:0] BITS_LONG = 4'h9;

	// Synchronised link pins travel together.
	typedef struct packed {
		logic clkPin;
		logic dataPin;
	} ssp_link_t;

	typedef enum {
		TX_IDLE,
		TX_SHIFT
	} ssp_tx_state_t;

endpackage

// ---- hdl/ssp_sync_slave.sv ----
// Overview of operation
// [RQ1] Slave mode is active when sync mode is on and clock source select is clear.
// [RQ2] The outside master drives the shift clock; the device never drives it.
// [RQ3] Shifting depends only on the pin clock, so it keeps working in low-power modes.
// [RQ4] Slave transmit buffers, flags and ninth bit work as in master transmit.
// [RQ5] With two words queued, the first moves to the shifter at once.
// [RQ6] The second word waits in the buffer and the empty flag stays clear.
// [RQ7] After the first word ends, the second loads and the empty flag sets.
// [RQ8] Transmit empty with its enable set raises the wake interrupt; the code raises it only while transmit is active.
// [RQ9] Software sets sync and port enable and clears clock source select.
// [RQ10] Software clears both receive enables before transmitting.
// [RQ11] Software sets transmit interrupt enable and nine-bit enable as wanted.
// [RQ12] Software writes the transmit ninth bit before loading the buffer.
// [RQ13] Transmit enable set plus a buffer write starts transmission.
// [RQ14] Single-receive enable is ignored; only continuous receive enables reception.
// [RQ15] Continuous receive accepts whole words during low-power modes.
// [RQ16] A completed word moves to the receive buffer; enabled interrupt wakes core.
// [RQ17] Receive-complete flag sets on a full word and requests an interrupt.
// [RQ18] Software sets receive nine-bit enable, then continuous receive.
// [RQ19] Received ninth bit and errors sit in the receive status register.
// [RQ20] The low eight received bits are read from the receive buffer.
// [RQ21] Clearing continuous receive clears the overrun error.
// [RQ22] Software sets global and peripheral interrupt enables.
// [RQ23] Transmit-empty flag clears only on a buffer write, not by software.
// [RQ24] Receive data is sampled on the falling edge of the shift clock.
// [RQ25] Shift-register-empty is read-only, set while the shifter is empty.
// [RQ26] The clock pin is input only; each bit steps with its external edges.
module ssp_sync_slave (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shiftClkIn,
	input wire logic dataIn,
	output logic dataOut,
	output logic dataOutEnN,
	output logic wakeIrq
);

	logic [1:0] clkSync_q;
	logic [1:0] dataSync_q;
	ssp_pkg::ssp_link_t link;
	logic clkPrev_q;
	logic riseEdge;
	logic fallEdge;
	logic [7:0] rxCtl_q;
	logic [7:0] txCtl_q;
	logic [7:0] baudCtl_q;
	logic [7:0] divHigh_q;
	logic [7:0] divLow_q;
	logic [1:0] irqEn_q;
	logic [8:0] txBuf_q;
	logic txBufFull_q;
	logic [8:0] txShift_q;
	logic [3:0] txCount_q;
	logic txEmptyFlag_q;
	ssp_pkg::ssp_tx_state_t txState_q;
	logic [8:0] rxShift_q;
	logic [3:0] rxCount_q;
	logic [8:0] rxBuf_q;
	logic rxFlag_q;
	logic overrun_q;
	logic slaveMode;
	logic portOn;
	logic txActive;
	logic rxActive;
	logic apbWrite;
	logic apbRead;
	logic txBufWrite;
	logic rxBufRead;
	logic txLoad;
	logic txWordDone;
	logic rxWordDone;
	logic [3:0] txBits;
	logic [3:0] rxBits;

	// Both pins cross from the master's domain through two flops first.
	// The clock stages reset to the idle-high level of the pin, so that the release
	// of reset is never mistaken for a rising edge of the shift clock.
	always_ff @(posedge clk) begin
		if (rst) begin
			clkSync_q <= 2'h3;
			dataSync_q <= 2'h0;
			clkPrev_q <= 1'b1;
		end else begin
			clkSync_q <= {clkSync_q[0], shiftClkIn};
			dataSync_q <= {dataSync_q[0], dataIn};
			clkPrev_q <= link.clkPin;
		end
	end

	// Edges are found on the second stage only.
	assign link = '{clkPin: clkSync_q[1], dataPin: dataSync_q[1]};
	assign riseEdge = link.clkPin & ~clkPrev_q;
	assign fallEdge = ~link.clkPin & clkPrev_q; // see [RQ26]

	// Mode decode; no shift clock is ever driven out.
	assign portOn = rxCtl_q[ssp_pkg::RS_PORT_EN];
	assign slaveMode = portOn & txCtl_q[ssp_pkg::TS_SYNC] & ~txCtl_q[ssp_pkg::TS_CLK_SRC]; // see [RQ1] see [RQ2]
	assign txActive = slaveMode & txCtl_q[ssp_pkg::TS_TX_EN]; // see [RQ13]
	assign rxActive = slaveMode & rxCtl_q[ssp_pkg::RS_CONT_EN]; // see [RQ14]
	assign txBits = txCtl_q[ssp_pkg::TS_TX9_EN] ? ssp_pkg::BITS_LONG : ssp_pkg::BITS_SHORT;
	assign rxBits = rxCtl_q[ssp_pkg::RS_RX9_EN] ? ssp_pkg::BITS_LONG : ssp_pkg::BITS_SHORT;

	// APB decode: zero wait states, writes and reads take effect in the access phase.
	assign apbWrite = psel & penable & pwrite;
	assign apbRead = psel & penable & ~pwrite;
	assign txBufWrite = apbWrite & (paddr == ssp_pkg::ADDR_TX_BUF);
	assign rxBufRead = apbRead & (paddr == ssp_pkg::ADDR_RX_BUF);

	// Buffer to shifter move happens whenever transmit is active, the shifter is idle and a word waits.
	assign txLoad = txActive & txBufFull_q & (txState_q == ssp_pkg::TX_IDLE); // see [RQ5]
	assign txWordDone = (txState_q == ssp_pkg::TX_SHIFT) & fallEdge & (txCount_q == txBits);
	assign rxWordDone = rxActive & fallEdge & (rxCount_q + 4'h1 == rxBits);

	// Control registers written by software as whole bytes, interrupt control as its two enables only; the read mux replaces the status bits.
	always_ff @(posedge clk) begin
		if (rst) begin
			rxCtl_q <= ssp_pkg::RESET_BYTE;
			txCtl_q <= ssp_pkg::RESET_BYTE;
			baudCtl_q <= ssp_pkg::RESET_BYTE;
			divHigh_q <= ssp_pkg::RESET_BYTE;
			divLow_q <= ssp_pkg::RESET_BYTE;
			irqEn_q <= 2'h0;
		end else if (apbWrite) begin
			case (paddr)
				ssp_pkg::ADDR_RX_STATUS: rxCtl_q <= pwdata[7:0];
				ssp_pkg::ADDR_TX_STATUS: txCtl_q <= pwdata[7:0];
				ssp_pkg::ADDR_BAUD_CTRL: baudCtl_q <= pwdata[7:0];
				ssp_pkg::ADDR_DIV_HIGH: divHigh_q <= pwdata[7:0];
				ssp_pkg::ADDR_DIV_LOW: divLow_q <= pwdata[7:0];
				ssp_pkg::ADDR_IRQ_CTRL: irqEn_q <= pwdata[1:0];
				default: irqEn_q <= irqEn_q;
			endcase
		end
	end

	// Transmit buffer; the ninth bit is captured with the byte, so it must be set first.
	always_ff @(posedge clk) begin
		if (rst) begin
			txBuf_q <= 9'h000;
			txBufFull_q <= 1'b0;
		end else if (txBufWrite) begin
			txBuf_q <= {txCtl_q[ssp_pkg::TS_TX_NINTH], pwdata[7:0]}; // see [RQ12]
			txBufFull_q <= 1'b1;
		end else if (txLoad) begin
			txBufFull_q <= 1'b0; // see [RQ6]
		end
	end

	// Empty flag: set on the move, cleared only by a buffer write; set wins.
	always_ff @(posedge clk) begin
		if (rst) begin
			txEmptyFlag_q <= 1'b1;
		end else if (txLoad) begin
			txEmptyFlag_q <= 1'b1; // see [RQ7] see [RQ4]
		end else if (txBufWrite) begin
			txEmptyFlag_q <= 1'b0; // see [RQ23]
		end
	end

	// Transmit shifter: drive a new bit after each falling edge, LSB first.
	always_ff @(posedge clk) begin
		if (rst) begin
			txState_q <= ssp_pkg::TX_IDLE;
			txShift_q <= 9'h000;
			txCount_q <= ssp_pkg::BIT_COUNT_ZERO;
		end else begin
			case (txState_q)
				ssp_pkg::TX_IDLE: begin
					if (txLoad) begin
						txShift_q <= txBuf_q;
						txCount_q <= ssp_pkg::BIT_COUNT_ZERO;
						txState_q <= ssp_pkg::TX_SHIFT; // see [RQ3]
					end
				end
				ssp_pkg::TX_SHIFT: begin
					if (!txActive) begin
						txState_q <= ssp_pkg::TX_IDLE;
					end else if (riseEdge) begin
						txCount_q <= txCount_q + 4'h1;
					end else if (fallEdge) begin
						txShift_q <= {1'b0, txShift_q[8:1]};
						if (txCount_q == txBits) begin
							txState_q <= ssp_pkg::TX_IDLE;
						end
					end
				end
				default: txState_q <= ssp_pkg::TX_IDLE;
			endcase
		end
	end

	// Pin drive: enable is low while driving; the bus is released when idle.
	always_ff @(posedge clk) begin
		if (rst) begin
			dataOut <= 1'b0;
			dataOutEnN <= 1'b1;
		end else begin
			dataOut <= txShift_q[0];
			dataOutEnN <= ~(txState_q == ssp_pkg::TX_SHIFT);
		end
	end

	// Receive shifter samples the data pin on falling edges only.
	always_ff @(posedge clk) begin
		if (rst || !rxActive) begin
			rxShift_q <= 9'h000;
			rxCount_q <= ssp_pkg::BIT_COUNT_ZERO;
		end else if (fallEdge) begin
			rxShift_q <= {link.dataPin, rxShift_q[8:1]}; // see [RQ24] see [RQ15]
			rxCount_q <= rxWordDone ? ssp_pkg::BIT_COUNT_ZERO : rxCount_q + 4'h1;
		end
	end

	// Word completion: to buffer unless the last word is unread, else overrun.
	always_ff @(posedge clk) begin
		if (rst) begin
			rxBuf_q <= 9'h000;
			rxFlag_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			if (rxWordDone && !rxFlag_q) begin
				rxBuf_q <= rxCtl_q[ssp_pkg::RS_RX9_EN] ? {link.dataPin, rxShift_q[8:1]}
					: {1'b0, link.dataPin, rxShift_q[8:2]}; // see [RQ16]
			end
			if (rxWordDone && !rxFlag_q) begin
				rxFlag_q <= 1'b1; // see [RQ17]
			end else if (rxBufRead) begin
				rxFlag_q <= 1'b0;
			end
			if (!rxActive) begin
				overrun_q <= 1'b0; // see [RQ21]
			end else if (rxWordDone && rxFlag_q) begin
				overrun_q <= 1'b1;
			end
		end
	end

	// Wake line from the two flags and their enables; the transmit side only while transmit is active.
	always_ff @(posedge clk) begin
		if (rst) begin
			wakeIrq <= 1'b0;
		end else begin
			wakeIrq <= (txEmptyFlag_q & irqEn_q[ssp_pkg::IC_TX_IE] & txActive)
				| (rxFlag_q & irqEn_q[ssp_pkg::IC_RX_IE]); // see [RQ8] see [RQ16]
		end
	end

	// Read mux, registered so the answer comes from a flop in the access phase.
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > ssp_pkg::ADDR_IRQ_CTRL);
			prdata <= 32'h0000_0000;
			case (paddr)
				ssp_pkg::ADDR_RX_STATUS: prdata[7:0] <= {rxCtl_q[7:4], 1'b0, 1'b0,
					overrun_q, rxBuf_q[8]}; // see [RQ19]
				ssp_pkg::ADDR_TX_BUF: prdata[8:0] <= txBuf_q;
				ssp_pkg::ADDR_TX_STATUS: prdata[7:0] <= {txCtl_q[7:2],
					txState_q == ssp_pkg::TX_IDLE, txCtl_q[0]}; // see [RQ25]
				ssp_pkg::ADDR_BAUD_CTRL: prdata[7:0] <= baudCtl_q;
				ssp_pkg::ADDR_DIV_HIGH: prdata[7:0] <= divHigh_q;
				ssp_pkg::ADDR_DIV_LOW: prdata[7:0] <= divLow_q;
				ssp_pkg::ADDR_RX_BUF: prdata[7:0] <= rxBuf_q[7:0]; // see [RQ20]
				ssp_pkg::ADDR_IRQ_CTRL: prdata[7:0] <= {2'h0, rxFlag_q, txEmptyFlag_q,
					2'h0, irqEn_q};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Checks.
	sequence s_loadStart;
		txLoad;
	endsequence

	a_tx_load_flag: assert property (@(posedge clk) disable iff (rst)
		s_loadStart |=> txEmptyFlag_q && !txBufFull_q) // see [RQ7]
		else $error("empty flag not set after load");
	a_flag_no_clear: assert property (@(posedge clk) disable iff (rst)
		$fell(txEmptyFlag_q) |-> $past(txBufWrite)) // see [RQ23]
		else $error("empty flag cleared without write");
	a_second_waits: assert property (@(posedge clk) disable iff (rst)
		(txState_q == ssp_pkg::TX_SHIFT && txBufFull_q) |-> !txEmptyFlag_q) // see [RQ6]
		else $error("flag set while word waits");
	a_load_to_shift: assert property (@(posedge clk) disable iff (rst)
		s_loadStart |=> txState_q == ssp_pkg::TX_SHIFT) // see [RQ5]
		else $error("load did not start shift");
	a_rx_flag_set: assert property (@(posedge clk) disable iff (rst)
		(rxWordDone && !rxFlag_q) |=> rxFlag_q) // see [RQ17]
		else $error("receive flag not set");
	a_rx_gate: assert property (@(posedge clk) disable iff (rst)
		!rxActive |=> rxCount_q == ssp_pkg::BIT_COUNT_ZERO) // see [RQ14]
		else $error("receive ran while disabled");
	a_err_clear: assert property (@(posedge clk) disable iff (rst)
		!rxActive |=> !overrun_q) // see [RQ21]
		else $error("overrun not cleared");
	a_rx_sample_edge: assert property (@(posedge clk) disable iff (rst)
		(rxActive && $changed(rxCount_q) && $past(rxActive)) |-> $past(fallEdge)) // see [RQ24]
		else $error("receive stepped without falling edge");
	a_wake_tx: assert property (@(posedge clk) disable iff (rst)
		(txEmptyFlag_q && irqEn_q[ssp_pkg::IC_TX_IE] && txActive) |=> wakeIrq) // see [RQ8]
		else $error("transmit wake missing");

	// Transmit word end and pin release.
	sequence s_txEnd;
		txWordDone;
	endsequence

	sequence s_txStopped;
		txState_q == ssp_pkg::TX_SHIFT && !txActive;
	endsequence

	a_word_end: assert property (@(posedge clk) disable iff (rst) // see [RQ7]
		s_txEnd |=> txState_q == ssp_pkg::TX_IDLE)
		else $error("shifter busy after last bit");
	a_pin_release: assert property (@(posedge clk) disable iff (rst) // see [RQ2]
		txState_q == ssp_pkg::TX_IDLE |=> dataOutEnN)
		else $error("data pin driven while idle");
	a_tx_disable: assert property (@(posedge clk) disable iff (rst) // see [RQ13]
		s_txStopped |=> txState_q == ssp_pkg::TX_IDLE)
		else $error("shifter ran with transmit off");
	a_buf_fill: assert property (@(posedge clk) disable iff (rst) // see [RQ4]
		txBufWrite |=> txBufFull_q)
		else $error("buffer write not held");
	// Outside slave mode the pin must settle released within two cycles.
	a_not_slave_quiet: assert property (@(posedge clk) disable iff (rst) // see [RQ1]
		!slaveMode |-> ##2 dataOutEnN)
		else $error("pin driven outside slave mode");

	// Receive stepping, dropped words and the receive wake line.
	sequence s_rxStep;
		rxActive && fallEdge;
	endsequence

	sequence s_wordIn;
		rxWordDone && !rxFlag_q;
	endsequence

	sequence s_wordDrop;
		rxWordDone && rxFlag_q;
	endsequence

	a_rx_step: assert property (@(posedge clk) disable iff (rst) // see [RQ26]
		s_rxStep |=> $changed(rxCount_q))
		else $error("receive missed a falling edge");
	a_single_ignored: assert property (@(posedge clk) disable iff (rst) // see [RQ14]
		(rxCtl_q[ssp_pkg::RS_SINGLE_EN] && !rxCtl_q[ssp_pkg::RS_CONT_EN])
		|=> rxCount_q == ssp_pkg::BIT_COUNT_ZERO)
		else $error("single receive enable took effect");
	a_overrun_set: assert property (@(posedge clk) disable iff (rst) // see [RQ21]
		s_wordDrop |=> overrun_q)
		else $error("overrun not flagged");
	a_drop_keeps_buf: assert property (@(posedge clk) disable iff (rst) // see [RQ16]
		s_wordDrop |=> $stable(rxBuf_q))
		else $error("unread word overwritten");
	a_rx9_zero: assert property (@(posedge clk) disable iff (rst) // see [RQ19]
		(s_wordIn and !rxCtl_q[ssp_pkg::RS_RX9_EN]) |=> !rxBuf_q[8])
		else $error("ninth bit set in eight-bit mode");
	a_wake_rx: assert property (@(posedge clk) disable iff (rst) // see [RQ16]
		(rxFlag_q && irqEn_q[ssp_pkg::IC_RX_IE]) |=> wakeIrq)
		else $error("receive wake missing");

endmodule // ssp_sync_slave

// ---- sim/ssp_master_model.sv ----
// Outside master for slave-mode traffic: it makes the shift clock and data.
module ssp_master_model (
	output logic shiftClk,
	output logic dataToDev,
	input wire logic dataFromDev
);
	timeunit 1ns;
	timeprecision 1ns;
	int halfNs = 160;
	logic [8:0] got;
	// The clock stands high between frames and the device never drives it.
	initial begin
		shiftClk = 1'b1;
		dataToDev = 1'b0;
		got = 9'h000;
	end
	// One word LSB first; data moves on rising edges so it is steady at each fall.
	task automatic frame(input logic [8:0] w, input int n, input bit tail);
		#7;
		got = 9'h000;
		dataToDev = w[0];
		#(halfNs);
		for (int i = 0; i < n; i++) begin
			// The device moves its bit after each fall, so each bit is taken just before it.
			got[i] = dataFromDev;
			shiftClk = 1'b0;
			#(halfNs) shiftClk = 1'b1;
			// After the word the line shows the inverse of the last bit, not a held value.
			dataToDev = (i + 1 < n) ? w[i + 1] : ~w[i];
			#(halfNs);
		end
		if (tail) begin
			shiftClk = 1'b0;
			#(halfNs) shiftClk = 1'b1;
			#(halfNs);
		end
	endtask
endmodule // ssp_master_model

// ---- sim/sync_serial_slave_port_tb.sv ----
module sync_serial_slave_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, shiftClk, dataIn, dataOut, dataOutEnN, wakeIrq, err;
	logic [7:0] rd;
	logic [8:0] w;
	logic [8:0] txQ[$];
	int n_mismatch = 0;
	int tests_run = 0;
	// The bench clock, 25 MHz.
	always #20 clk = ~clk;
	ssp_sync_slave i_ssp_sync_slave (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shiftClkIn(shiftClk), .dataIn(dataIn), .dataOut(dataOut),
		.dataOutEnN(dataOutEnN), .wakeIrq(wakeIrq));
	ssp_master_model i_ssp_master_model (.shiftClk(shiftClk), .dataToDev(dataIn),
		.dataFromDev(dataOut));
	// Report the verdict and stop.
	task automatic wrap_up();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Compare one value with the model's expectation.
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; the request stands until pready is seen high at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			wrap_up();
		end
		@(posedge clk);
	endtask
	task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		check({1'b0, rd & m}, {1'b0, e});
	endtask
	// Polls are bounded so a flag that never rises ends the run as a failure.
	task automatic waitFlag(input int b);
		for (int k = 0; k < 100; k++) begin
			apb(1'b0, ssp_pkg::ADDR_IRQ_CTRL, 8'h00);
			if (rd[b] === 1'b1) begin
				return;
			end
		end
		n_mismatch++;
		wrap_up();
	endtask
	// Main sequence: registers, transmit, then receive.
	initial begin
		void'($urandom(47));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdm(ssp_pkg::ADDR_TX_STATUS, 8'hFF, ssp_pkg::TX_STATUS_RESET);
		apb(1'b0, 8'h20, 8'h00);
		check({err, rd}, 9'h100);
		apb(1'b1, ssp_pkg::ADDR_IRQ_CTRL, 8'h01);
		rdm(ssp_pkg::ADDR_IRQ_CTRL, 8'hFF, 8'h11);
		apb(1'b1, ssp_pkg::ADDR_RX_STATUS, 8'h80);
		apb(1'b1, ssp_pkg::ADDR_TX_STATUS, 8'h30);
		rdm(ssp_pkg::ADDR_IRQ_CTRL, 8'hFF, 8'h11);
		check({8'h00, wakeIrq}, 9'h001);
		for (int j = 0; j < 2; j++) begin
			w = 9'($urandom) & 9'h0FF;
			txQ.push_back(w);
			apb(1'b1, ssp_pkg::ADDR_TX_BUF, w[7:0]);
		end
		rdm(ssp_pkg::ADDR_IRQ_CTRL, 8'hFF, 8'h01);
		check({wakeIrq, dataOutEnN}, 9'h000);
		for (int j = 0; j < 2; j++) begin
			i_ssp_master_model.frame(9'($urandom), 8, 1'b1);
			check(i_ssp_master_model.got, txQ.pop_front());
			rdm(ssp_pkg::ADDR_IRQ_CTRL, 8'h10, 8'h10);
		end
		rdm(ssp_pkg::ADDR_TX_STATUS, 8'hFF, 8'h32);
		check({wakeIrq, dataOutEnN}, 9'h003);
		// Nine-bit word at a slow master pace.
		i_ssp_master_model.halfNs = 400;
		apb(1'b1, ssp_pkg::ADDR_TX_STATUS, 8'h71);
		w = 9'($urandom) | 9'h100;
		apb(1'b1, ssp_pkg::ADDR_TX_BUF, w[7:0]);
		i_ssp_master_model.frame(9'h000, 9, 1'b1);
		check(i_ssp_master_model.got, w);
		i_ssp_master_model.halfNs = 160;
		// Master clock source selected: the port is not a slave and must not drive.
		apb(1'b1, ssp_pkg::ADDR_TX_STATUS, 8'hB0);
		apb(1'b1, ssp_pkg::ADDR_TX_BUF, 8'h5A);
		repeat (4) apb(1'b0, ssp_pkg::ADDR_TX_STATUS, 8'h00);
		check({8'h00, dataOutEnN}, 9'h001);
		apb(1'b1, ssp_pkg::ADDR_TX_STATUS, 8'h10);
		apb(1'b1, ssp_pkg::ADDR_IRQ_CTRL, 8'h02);
		apb(1'b1, ssp_pkg::ADDR_RX_STATUS, 8'hA0);
		i_ssp_master_model.frame(9'($urandom), 8, 1'b0);
		rdm(ssp_pkg::ADDR_IRQ_CTRL, 8'h20, 8'h00);
		apb(1'b1, ssp_pkg::ADDR_RX_STATUS, 8'hB0);
		for (int k = 0; k < 2; k++) begin
			if (k == 1) begin
				apb(1'b1, ssp_pkg::ADDR_RX_STATUS, 8'hF0);
			end
			w = 9'($urandom);
			i_ssp_master_model.frame(w, 8 + k, 1'b0);
			waitFlag(ssp_pkg::IC_RX_FLAG);
			check({8'h00, wakeIrq}, 9'h001);
			rdm(ssp_pkg::ADDR_RX_STATUS, 8'h01, 8'(k & w[8]));
			rdm(ssp_pkg::ADDR_RX_BUF, 8'hFF, w[7:0]);
			rdm(ssp_pkg::ADDR_IRQ_CTRL, 8'h20, 8'h00);
		end
		// A second word before the first is read is dropped and flagged.
		w = 9'($urandom);
		i_ssp_master_model.frame(w, 9, 1'b0);
		waitFlag(ssp_pkg::IC_RX_FLAG);
		i_ssp_master_model.frame(~w, 9, 1'b0);
		rdm(ssp_pkg::ADDR_RX_STATUS, 8'h02, 8'h02);
		rdm(ssp_pkg::ADDR_RX_BUF, 8'hFF, w[7:0]);
		apb(1'b1, ssp_pkg::ADDR_RX_STATUS, 8'hC0);
		rdm(ssp_pkg::ADDR_RX_STATUS, 8'h02, 8'h00);
		wrap_up();
	end
endmodule // sync_serial_slave_port_tb
